// ---- tlbx_unit.sv ----
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
module tlbx_unit
	import tlbx_pkg::*;
(
	input wire logic I_CLOCK,
	input wire logic I_NRST,
	input wire logic I_WB_CYC,
	input wire logic I_WB_STB,
	input wire logic I_WB_WE,
	input wire logic [7:0] I_WB_ADR,
	input wire logic [3:0] I_WB_SEL,
	input wire logic [31:0] I_WB_DAT,
	output logic [31:0] O_WB_DAT,
	output logic O_WB_ACK,
	input wire logic I_ACC_VALID,
	input wire tlbx_acc_t I_ACC,
	input wire tlbx_way_t I_WAYS,
	output logic O_ACC_ABORT,
	output logic O_EXC,
	output logic [31:0] O_EXC_VECTOR,
	input wire logic I_TRANSLATION_LOAD_INSTRUCTION,
	output logic O_LOAD_VALID,
	output tlbx_load_t O_LOAD,
	input wire logic I_RTE,
	output logic [31:0] O_STATUS
);
	logic [31:0] page_hi_ff, page_lo_ff, fault_ff, cause_ff, spc_ff;
	logic [31:0] status_ff, sstatus_ff, ctrl_ff, vbase_ff;
	logic [31:0] rdata_ff;
	logic ack_ff, exc_ff, load_valid_ff;
	logic [31:0] vector_ff;
	tlbx_load_t load_ff;
	tlbx_exc_t kind;
	logic [3:0] hitv, invm;
	logic [1:0] hit_way, cur_rc, nxt_rc;
	logic [1:0] hit_pr;
	logic pr_ok, take, bus_wr;
	logic [11:0] nxt_cause;
	logic [31:0] nxt_vector, acc_addr, acc_pc;
	logic [4:0] nxt_index;

	assign acc_addr = I_ACC.addr;
	assign acc_pc = I_ACC.pc;
	assign cur_rc = ctrl_ff[CTRL_RC_LSB +: 2];
	assign hitv = I_WAYS.tag_hit & I_WAYS.valid;
	assign invm = I_WAYS.tag_hit & ~I_WAYS.valid;
	assign hit_way = tlbx_lowest(hitv);
	assign hit_pr = I_WAYS.pr[{hit_way, 1'b0} +: 2];
	// user mode needs the user bit; writes also need the write bit
	assign pr_ok = (status_ff[SR_MD] | hit_pr[PR_USER]) &
		(~I_ACC.write | hit_pr[PR_WRITE]); // RL3

	always_comb begin
		kind = EXC_NONE;
		if (I_ACC_VALID && !status_ff[SR_BL]) begin // RL13
			if (|hitv) begin
				if (!pr_ok) begin
					kind = EXC_PROT; // RL3
				end else if (I_ACC.write && !I_WAYS.dirty[hit_way]) begin
					kind = EXC_FIRSTWR; // RL5
				end
			end else if (|invm) begin
				kind = EXC_INVALID; // RL4
			end else begin
				kind = EXC_MISS; // RL2
			end
		end
	end

	assign take = (kind != EXC_NONE); // RL1
	// abort in the same cycle so the access never commits
	assign O_ACC_ABORT = take; // RL25

	always_comb begin
		nxt_cause = CAUSE_FIRST_WR; // RL10
		nxt_rc = hit_way; // RL16
		nxt_vector = vbase_ff + VEC_GENERAL; // RL19
		case (kind)
			EXC_MISS: begin
				nxt_cause = I_ACC.write ? CAUSE_ST_MISS : CAUSE_LD_MISS; // RL8
				nxt_vector = vbase_ff + VEC_MISS; // RL18
				if (&I_WAYS.valid) begin
					nxt_rc = cur_rc + RC_STEP; // RL14
				end else begin
					nxt_rc = tlbx_lowest(~I_WAYS.valid); // RL15
				end
			end
			EXC_INVALID: begin
				nxt_cause = I_ACC.write ? CAUSE_ST_MISS : CAUSE_LD_MISS; // RL8
				nxt_rc = tlbx_lowest(invm); // RL17
			end
			EXC_PROT: begin
				nxt_cause = I_ACC.write ? CAUSE_ST_PROT : CAUSE_LD_PROT; // RL9
			end
			default: begin
				nxt_cause = CAUSE_FIRST_WR;
			end
		endcase
	end

	assign bus_wr = I_WB_CYC & I_WB_STB & I_WB_WE & ~ack_ff;

	// fault captures beat a software write in the same cycle
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			page_hi_ff <= RST_ZERO;
			fault_ff <= RST_ZERO;
			cause_ff <= RST_ZERO;
			spc_ff <= RST_ZERO;
			sstatus_ff <= RST_ZERO;
		end else if (take) begin
			page_hi_ff <= {acc_addr[31:VPN_LSB],
				page_hi_ff[VPN_LSB-1:0]}; // RL6
			fault_ff <= acc_addr; // RL7
			cause_ff <= {20'h00000, nxt_cause};
			spc_ff <= I_ACC.dslot ? I_ACC.branch_pc : acc_pc; // RL11
			sstatus_ff <= status_ff; // RL12
		end else if (bus_wr) begin
			case (I_WB_ADR)
				ADR_PAGE_HI:
					page_hi_ff <= tlbx_merge(page_hi_ff, I_WB_DAT, I_WB_SEL);
				ADR_FAULT:
					fault_ff <= tlbx_merge(fault_ff, I_WB_DAT, I_WB_SEL);
				ADR_CAUSE:
					cause_ff <= tlbx_merge(cause_ff, I_WB_DAT, I_WB_SEL);
				ADR_SPC:
					spc_ff <= tlbx_merge(spc_ff, I_WB_DAT, I_WB_SEL);
				ADR_SSTATUS:
					sstatus_ff <= tlbx_merge(sstatus_ff, I_WB_DAT, I_WB_SEL);
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			status_ff <= RST_STATUS;
		end else if (take) begin
			status_ff[SR_MD] <= 1'b1; // RL13
			status_ff[SR_BL] <= 1'b1; // RL13
			status_ff[SR_RB] <= 1'b1; // RL13
		end else if (I_RTE) begin
			status_ff <= sstatus_ff;
		end else if (bus_wr && I_WB_ADR == ADR_STATUS) begin
			status_ff <= tlbx_merge(status_ff, I_WB_DAT, I_WB_SEL);
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			ctrl_ff <= RST_ZERO;
		end else if (take) begin
			ctrl_ff[CTRL_RC_LSB +: 2] <= nxt_rc;
		end else if (bus_wr && I_WB_ADR == ADR_CTRL) begin
			ctrl_ff <= tlbx_merge(ctrl_ff, I_WB_DAT, I_WB_SEL); // RL22
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			page_lo_ff <= RST_ZERO;
			vbase_ff <= RST_ZERO;
		end else if (bus_wr) begin
			if (I_WB_ADR == ADR_PAGE_LO) begin
				page_lo_ff <= tlbx_merge(page_lo_ff, I_WB_DAT, I_WB_SEL); // RL21
			end
			if (I_WB_ADR == ADR_VBASE) begin
				vbase_ff <= tlbx_merge(vbase_ff, I_WB_DAT, I_WB_SEL);
			end
		end
	end

	// unmapped addresses still ack, read zero, drop writes
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			ack_ff <= 1'b0;
			rdata_ff <= RST_ZERO;
		end else begin
			ack_ff <= I_WB_CYC & I_WB_STB & ~ack_ff;
			case (I_WB_ADR)
				ADR_PAGE_HI: rdata_ff <= page_hi_ff;
				ADR_PAGE_LO: rdata_ff <= page_lo_ff;
				ADR_FAULT: rdata_ff <= fault_ff;
				ADR_CAUSE: rdata_ff <= cause_ff;
				ADR_SPC: rdata_ff <= spc_ff;
				ADR_STATUS: rdata_ff <= status_ff;
				ADR_SSTATUS: rdata_ff <= sstatus_ff;
				ADR_CTRL: rdata_ff <= ctrl_ff;
				ADR_VBASE: rdata_ff <= vbase_ff;
				default: rdata_ff <= RST_ZERO;
			endcase
		end
	end

	// vector leaves one cycle later, after every capture has landed
	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			exc_ff <= 1'b0;
			vector_ff <= RST_ZERO;
		end else begin
			exc_ff <= take; // RL25
			if (take) begin
				vector_ff <= nxt_vector;
			end
		end
	end

	assign nxt_index = page_hi_ff[IDX_MSB:IDX_LSB] ^
		(ctrl_ff[CTRL_IX] ? page_hi_ff[ADDRESS_SPACE_IDENTIFIER_IDX_MSB:0] : 5'h00); // RL24

	always_ff @(posedge I_CLOCK) begin
		if (!I_NRST) begin
			load_valid_ff <= 1'b0;
			load_ff <= '0;
		end else begin
			load_valid_ff <= I_TRANSLATION_LOAD_INSTRUCTION;
			if (I_TRANSLATION_LOAD_INSTRUCTION) begin
				load_ff <= {nxt_index, cur_rc, page_hi_ff, page_lo_ff}; // RL20
			end
		end
	end

	assign O_WB_DAT = rdata_ff;
	assign O_WB_ACK = ack_ff;
	assign O_EXC = exc_ff;
	assign O_EXC_VECTOR = vector_ff;
	assign O_LOAD_VALID = load_valid_ff;
	assign O_LOAD = load_ff;
	assign O_STATUS = status_ff;

	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_NRST);

	sequence s_take;
		take;
	endsequence
	sequence s_entered;
		status_ff[SR_MD] && status_ff[SR_BL] && status_ff[SR_RB] && O_EXC;
	endsequence

	AST_ENTRY: assert property (s_take |=> s_entered) // RL13
		else $error("entry bits or exception pulse missing");
	AST_MASKED: assert property (status_ff[SR_BL] |-> !take) // RL13
		else $error("exception taken while blocked");
	AST_VPN: assert property (take |=> page_hi_ff[31:VPN_LSB] ==
		$past(acc_addr[31:VPN_LSB])) // RL6
		else $error("page number not captured");
	AST_FAULT: assert property (take |=> fault_ff == $past(acc_addr)) // RL7
		else $error("fault address not captured");
	AST_SPC: assert property (take && !I_ACC.dslot |=>
		spc_ff == $past(acc_pc)) // RL11
		else $error("saved pc wrong");
	AST_SSR: assert property (take |=> sstatus_ff == $past(status_ff)) // RL12
		else $error("saved status wrong");
	AST_MISS_LD: assert property (kind == EXC_MISS && !I_ACC.write |=>
		cause_ff[11:0] == CAUSE_LD_MISS) // RL8
		else $error("load miss cause wrong");
	AST_PROT_ST: assert property (kind == EXC_PROT && I_ACC.write |=>
		cause_ff[11:0] == CAUSE_ST_PROT) // RL9
		else $error("store protection cause wrong");
	AST_FIRSTWR: assert property (kind == EXC_FIRSTWR |->
		I_ACC.write ##1 cause_ff[11:0] == CAUSE_FIRST_WR) // RL10
		else $error("first write fault wrong");
	AST_RC_INC: assert property (kind == EXC_MISS && &I_WAYS.valid |=>
		ctrl_ff[CTRL_RC_LSB +: 2] == $past(cur_rc) + RC_STEP) // RL14
		else $error("replacement way not incremented");
	AST_VEC_MISS: assert property (kind == EXC_MISS |=>
		O_EXC_VECTOR == $past(vbase_ff) + VEC_MISS) // RL18
		else $error("miss vector wrong");
	AST_VEC_GEN: assert property (take && kind != EXC_MISS |=>
		O_EXC_VECTOR == $past(vbase_ff) + VEC_GENERAL) // RL19
		else $error("general vector wrong");
	AST_LOAD: assert property (I_TRANSLATION_LOAD_INSTRUCTION |=> O_LOAD_VALID &&
		O_LOAD.hi == $past(page_hi_ff) && O_LOAD.lo == $past(page_lo_ff)) // RL20
		else $error("translation load contents wrong");
endmodule

// ---- tlbx_pkg.sv ----
// Contract
// (RL1) Four exception kinds: miss, protection, invalid entry, first write.
// (RL2) Miss when no way's tag matches the address.
// (RL3) Protection fault when a valid match forbids this access kind.
// (RL4) Invalid-entry fault when the tag matches but valid is zero.
// (RL5) First-write fault on a permitted write to a valid clean page.
// (RL6) Every fault writes the faulting page number into page entry high.
// (RL7) Every fault writes the whole faulting address into fault address.
// (RL8) Miss or invalid: cause 040 for load, 060 for store.
// (RL9) Protection fault: cause 0A0 for load, 0C0 for store.
// (RL10) First-write fault: cause 080.
// (RL11) Saved PC is the faulting PC, or the branch PC in a delay slot.
// (RL12) Status at fault time is copied into the saved status.
// (RL13) Entry sets privilege, block and bank bits; block masks faults.
// (RL14) Miss with all ways valid increments the replacement way field.
// (RL15) Miss with an invalid way picks the lowest invalid way.
// (RL16) Protection and first-write faults record the hitting way.
// (RL17) Invalid-entry fault records the matching invalid way.
// (RL18) Miss vectors to vector base plus 400.
// (RL19) Other faults vector to vector base plus 100.
// (RL20) Translation load copies page entry high and low into the buffer.
// (RL21) Handler fills page entry low before the translation load.
// (RL22) Handler choosing a way writes the replacement field first.
// (RL23) Handler returns only after two translation loads.
// (RL24) Index is page bits 16:12, XORed with space id when index mode set.
// (RL25) All captures finish before the handler fetch; the access aborts.
package tlbx_pkg;
	localparam logic [7:0] ADR_PAGE_HI = 8'h00;
	localparam logic [7:0] ADR_PAGE_LO = 8'h04;
	localparam logic [7:0] ADR_FAULT = 8'h08;
	localparam logic [7:0] ADR_CAUSE = 8'h0c;
	localparam logic [7:0] ADR_SPC = 8'h10;
	localparam logic [7:0] ADR_STATUS = 8'h14;
	localparam logic [7:0] ADR_SSTATUS = 8'h18;
	localparam logic [7:0] ADR_CTRL = 8'h1c;
	localparam logic [7:0] ADR_VBASE = 8'h20;
	localparam logic [11:0] CAUSE_LD_MISS = 12'h040;
	localparam logic [11:0] CAUSE_ST_MISS = 12'h060;
	localparam logic [11:0] CAUSE_FIRST_WR = 12'h080;
	localparam logic [11:0] CAUSE_LD_PROT = 12'h0a0;
	localparam logic [11:0] CAUSE_ST_PROT = 12'h0c0;
	localparam logic [31:0] VEC_MISS = 32'h0000_0400;
	localparam logic [31:0] VEC_GENERAL = 32'h0000_0100;
	localparam int VPN_LSB = 10;
	localparam int IDX_MSB = 16;
	localparam int IDX_LSB = 12;
	localparam int ADDRESS_SPACE_IDENTIFIER_IDX_MSB = 4;
	localparam int CTRL_IX = 9;
	localparam int CTRL_RC_LSB = 6;
	localparam int SR_MD = 30;
	localparam int SR_RB = 29;
	localparam int SR_BL = 28;
	localparam int PR_USER = 1;
	localparam int PR_WRITE = 0;
	localparam logic [31:0] RST_STATUS = 32'h7000_00f0;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	localparam logic [1:0] RC_STEP = 2'h1;
	typedef enum {EXC_NONE, EXC_MISS, EXC_PROT, EXC_INVALID, EXC_FIRSTWR}
		tlbx_exc_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] pc;
		logic [31:0] branch_pc;
		logic write;
		logic dslot;
	} tlbx_acc_t;
	typedef struct packed {
		logic [3:0] tag_hit;
		logic [3:0] valid;
		logic [7:0] pr;
		logic [3:0] dirty;
	} tlbx_way_t;
	typedef struct packed {
		logic [4:0] index;
		logic [1:0] way;
		logic [31:0] hi;
		logic [31:0] lo;
	} tlbx_load_t;
	function automatic logic [1:0] tlbx_lowest(input logic [3:0] v);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (v[i]) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction
	function automatic logic [31:0] tlbx_merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] sel);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction
endpackage

// ---- tlbx_handler_model.sv ----
`timescale 1ns/1ns
module tlbx_handler_model (
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [1:0] i_wait,
	output logic o_translation_load_instruction,
	output logic o_rte
);
	// a slow handler stalls i_wait cycles before its loads
	initial begin
		o_translation_load_instruction = 1'b0;
		o_rte = 1'b0;
		forever begin
			@(posedge i_clk);
			if (i_go) begin
				repeat (i_wait) @(posedge i_clk);
				o_translation_load_instruction <= 1'b1;
				repeat (2) @(posedge i_clk);
				o_translation_load_instruction <= 1'b0;
				repeat (2) @(posedge i_clk);
				o_rte <= 1'b1;
				@(posedge i_clk);
				o_rte <= 1'b0;
			end
		end
	end
endmodule

// ---- tb_tlb_exception_unit.sv ----
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_tlb_exception_unit;
	import tlbx_pkg::*;
	logic I_CLOCK = 0, I_NRST = 0, cyc = 0, stb = 0, we = 0, av = 0, go = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [1:0] hw = 2'h0;
	logic [31:0] dat = 32'h0, rng = 32'h24, wbq, vb, rd, vec, st;
	logic ld, return_from_exception_instruction, ack, lv, ab, ex;
	tlbx_acc_t acc = '0;
	tlbx_way_t ways = '0;
	tlbx_load_t lt;
	int fail_count = 0, n_tests = 0;
	always #10 I_CLOCK = ~I_CLOCK;
	tlbx_unit DUT (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_WB_CYC(cyc),
		.I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
		.I_WB_DAT(dat), .O_WB_DAT(rd), .O_WB_ACK(ack), .I_ACC_VALID(av),
		.I_ACC(acc), .I_WAYS(ways), .O_ACC_ABORT(ab), .O_EXC(ex),
		.O_EXC_VECTOR(vec), .I_TRANSLATION_LOAD_INSTRUCTION(ld), .O_LOAD_VALID(lv), .O_LOAD(lt),
		.I_RTE(return_from_exception_instruction), .O_STATUS(st));
	tlbx_handler_model HM (.i_clk(I_CLOCK), .i_go(go), .i_wait(hw),
		.o_translation_load_instruction(ld), .o_rte(return_from_exception_instruction));
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		i = 0;
		@(posedge I_CLOCK);
		while (ack !== 1'b1) begin
			i++;
			if (i > 20) begin
				fail_count++;
				print_verdict();
			end
			@(posedge I_CLOCK);
		end
		wbq = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge I_CLOCK);
	endtask
	task automatic fault(input int k, input logic wr);
		tlbx_acc_t c;
		tlbx_way_t y;
		logic [11:0] cz;
		logic [31:0] vx, hi, lo;
		int rc, rx, ix, w, i;
		rc = int'(xs() & 32'h3);
		ix = int'(xs() & 32'h1);
		wb(1'b1, ADR_CTRL, (32'(ix) << 9) | (32'(rc) << 6));
		w = int'(xs() & 32'h3);
		c.addr = xs();
		c.pc = xs();
		c.branch_pc = xs();
		c.write = wr;
		c.dslot = rng[0];
		y = {4'h0, rng[7:4], rng[19:12], rng[11:8]};
		rx = w;
		vx = vb + VEC_GENERAL;
		cz = wr ? CAUSE_ST_MISS : CAUSE_LD_MISS;
		if (k == 0) begin
			vx = vb + VEC_MISS;
			rx = (rc + 1) % 4;
			for (i = 3; i >= 0; i--) begin
				if (!y.valid[i]) begin
					rx = i;
				end
			end
		end else begin
			y.tag_hit[w] = 1'b1;
			y.valid[w] = (k != 2);
			// status is user mode, so no rights at all faults either kind
			y.pr[2*w +: 2] = (k == 3) ? 2'h3 : 2'h0;
			y.dirty[w] = 1'b0;
		end
		if (k == 1) begin
			cz = wr ? CAUSE_ST_PROT : CAUSE_LD_PROT;
		end
		if (k == 3) begin
			cz = CAUSE_FIRST_WR;
		end
		acc <= c;
		ways <= y;
		av <= 1'b1;
		#1 `CHK("abort", 1'b1, ab)
		@(posedge I_CLOCK);
		av <= 1'b0;
		#1 `CHK("exc", 1'b1, ex)
		`CHK("vector", vx, vec)
		@(posedge I_CLOCK);
		wb(1'b0, ADR_FAULT, 32'h0);
		`CHK("fault addr", c.addr, wbq)
		wb(1'b0, ADR_PAGE_HI, 32'h0);
		`CHK("page hi", c.addr[31:10], wbq[31:10])
		wb(1'b0, ADR_CAUSE, 32'h0);
		`CHK("cause", {20'h0, cz}, wbq)
		wb(1'b0, ADR_SPC, 32'h0);
		`CHK("spc", c.dslot ? c.branch_pc : c.pc, wbq)
		wb(1'b0, ADR_SSTATUS, 32'h0);
		`CHK("sstatus", 32'h0, wbq)
		wb(1'b0, ADR_STATUS, 32'h0);
		`CHK("status", 32'h7000_0000, wbq)
		wb(1'b0, ADR_CTRL, 32'h0);
		`CHK("way", 2'(rx), wbq[7:6])
		lo = xs();
		hi = {c.addr[31:10], 10'h0} | (xs() & 32'hff);
		wb(1'b1, ADR_PAGE_LO, lo);
		wb(1'b1, ADR_PAGE_HI, hi);
		w = int'(xs() & 32'h3);
		wb(1'b1, ADR_CTRL, (32'(ix) << 9) | (32'(w) << 6));
		hw <= rng[9:8];
		go <= 1'b1;
		@(posedge I_CLOCK);
		go <= 1'b0;
		for (i = 0; i < 30 && lv !== 1'b1; i++) begin
			@(posedge I_CLOCK);
			#1;
		end
		`CHK("load valid", 1'b1, lv)
		if (lv !== 1'b1) begin
			print_verdict();
		end
		`CHK("index", hi[16:12] ^ (ix != 0 ? hi[4:0] : 5'h0), lt.index)
		`CHK("load", {2'(w), hi, lo}, {lt.way, lt.hi, lt.lo})
		for (i = 0; i < 30 && st[28] !== 1'b0; i++) begin
			@(posedge I_CLOCK);
			#1;
		end
		`CHK("restored", 32'h0, st)
		if (st !== 32'h0) begin
			print_verdict();
		end
		@(posedge I_CLOCK);
	endtask
	initial begin
		repeat (3) @(posedge I_CLOCK);
		`CHK("reset status", RST_STATUS, st)
		`CHK("reset exc", 1'b0, ex)
		`CHK("reset load", 1'b0, lv)
		`CHK("reset ack", 1'b0, ack)
		I_NRST <= 1'b1;
		wb(1'b1, ADR_STATUS, 32'h0);
		vb = xs() & 32'hffff_f000;
		wb(1'b1, ADR_VBASE, vb);
		wb(1'b0, 8'h80, 32'h0);
		`CHK("unmapped", 32'h0, wbq)
		for (int k = 0; k < 4; k++) begin
			for (int wr = 0; wr < 2; wr++) begin
				if (k != 3 || wr != 0) begin
					fault(k, wr[0]);
				end
			end
		end
		// block bit set: a miss must pass unnoticed
		wb(1'b1, ADR_STATUS, 32'h1000_0000);
		ways <= '0;
		av <= 1'b1;
		#1 `CHK("masked abort", 1'b0, ab)
		@(posedge I_CLOCK);
		av <= 1'b0;
		#1 `CHK("masked exc", 1'b0, ex)
		print_verdict();
	end
	initial begin
		repeat (20000) @(posedge I_CLOCK);
		fail_count++;
		print_verdict();
	end
endmodule
